// ### dpt_top.sv
// What this block does
// - codes 1000-1101 count port pin edges
// - fast oscillator keeps counting during emulator halt
// - first timer output field picks its pin
// - second timer output field picks its pin
// - control bit 1 selects period or pwm
// - control bit 0 inverts output polarity
// - second counter readable, writable, resets zero
// - scaler bit 7 selects pwm resolution
// - pre-divider 1/4/16/64 then 5-bit scaler
// - write-only 8-bit bound, resets zero
// - second bound lives at index 35h
//
// The Avalon-MM register port was decided locally.
module dpt_top
    import dpt_pkg::*;
#(
    parameter bit RESOLUTION_BUILD_OPTION = 1'b0
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_fast_rc_oscillator,
    input  wire logic        i_slow_rc_oscillator,
    input  wire logic        i_comparator_out,
    input  wire logic        i_port_a_pin0,
    input  wire logic        i_port_b_pin0,
    input  wire logic        i_port_a_pin4,
    input  wire logic        i_incircuit_emulator_halt,
    output logic             o_port_b_pin2,
    output logic             o_port_b_pin2_oe,
    output logic             o_port_a_pin3,
    output logic             o_port_a_pin3_oe,
    output logic             o_port_b_pin4,
    output logic             o_port_b_pin4_oe,
    output logic             o_port_b_pin5,
    output logic             o_port_b_pin5_oe,
    output logic             o_port_b_pin6,
    output logic             o_port_b_pin6_oe,
    output logic             o_port_b_pin7,
    output logic             o_port_b_pin7_oe
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // ************************************
    // decoding helpers
    // ************************************
    function automatic logic hit(input logic [7:0] a, input logic [5:0] ix);
        return (a[7:2] == ix) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [5:0] pre_mask(input logic [1:0] s);
        case (s)
            2'h0:    return PRE_MASK_1;
            2'h1:    return PRE_MASK_4;
            2'h2:    return PRE_MASK_16;
            default: return PRE_MASK_64;
        endcase
    endfunction

    // picks one tick from the selected source
    function automatic logic src_tick(input logic [3:0] s,
        input logic [SY_W-1:0] r, input logic [SY_W-1:0] f);
        logic run;
        run = !r[SY_HALT] && !f[SY_HALT];
        case (s)
            SRC_SYS:  return run;
            SRC_FAST: return r[SY_FAST];
            SRC_SLOW: return run && r[SY_SLOW];
            SRC_CMP:  return run && r[SY_CMP];
            SRC_A0_R: return run && r[SY_A0];
            SRC_A0_F: return run && f[SY_A0];
            SRC_B0_R: return run && r[SY_B0];
            SRC_B0_F: return run && f[SY_B0];
            SRC_A4_R: return run && r[SY_A4];
            SRC_A4_F: return run && f[SY_A4];
            default:  return 1'b0;
        endcase
    endfunction

    // ************************************
    // input synchronisers
    // ************************************
    logic [SY_W-1:0] s1_reg;
    logic [SY_W-1:0] s2_reg;
    logic [SY_W-1:0] s3_reg;
    logic [SY_W-1:0] raw;
    logic [SY_W-1:0] lvl;
    logic [SY_W-1:0] rise;
    logic [SY_W-1:0] fall;
    logic            halt;

    assign raw = {i_incircuit_emulator_halt, i_port_a_pin4,
                  i_port_b_pin0, i_port_a_pin0, i_comparator_out,
                  i_slow_rc_oscillator, i_fast_rc_oscillator};
    // halt as level, edges of the rest for ticks
    assign lvl  = {s2_reg[SY_HALT], {(SY_W-1){1'b0}}};
    assign rise = (s2_reg & ~s3_reg) | lvl;
    assign fall = (~s2_reg & s3_reg) | lvl;
    assign halt = s2_reg[SY_HALT];

    // two flops before use, third for edges
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ************************************
    // avalon slave: one wait state
    // ************************************
    logic        wait_reg;
    logic [7:0]  rdata_reg;
    logic        req;
    logic        acc;
    logic        wr;
    logic [7:0]  wd;
    logic [7:0]  ctrl_reg  [0:1];
    logic [7:0]  cnt_reg   [0:1];
    logic [7:0]  scale_reg [0:1];
    logic [7:0]  bound_reg [0:1];
    logic [7:0]  rd_next;

    assign req = i_avs_read || i_avs_write;
    assign acc = req && !wait_reg;
    assign wr  = acc && i_avs_write && i_avs_byteenable[0];
    assign wd  = i_avs_writedata[7:0];
    assign o_avs_waitrequest = wait_reg;
    assign o_avs_readdata    = {24'h0, rdata_reg};

    // readable: controls and counters; write-only read zero
    assign rd_next =
        hit(i_avs_address, IDX_CTRL[0])  ? ctrl_reg[0] :
        hit(i_avs_address, IDX_COUNT[0]) ? cnt_reg[0]  :
        hit(i_avs_address, IDX_CTRL[1])  ? ctrl_reg[1] :
        hit(i_avs_address, IDX_COUNT[1]) ? cnt_reg[1]  :
        RST_BYTE;

    // wait drops for the single accepting cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= RST_BYTE;
        end else begin
            wait_reg <= !(req && wait_reg);
            if (req && wait_reg) begin
                rdata_reg <= rd_next;
            end
        end
    end

    // ************************************
    // timers
    // ************************************
    logic [1:0] tick;
    logic [1:0] div_done;
    logic [1:0] wave_reg;
    logic [2:0] pin_reg [0:1];
    logic [2:0] oe_reg  [0:1];

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tmr
            logic [5:0] pre_reg;
            logic [4:0] div_reg;
            logic [5:0] mask;
            logic       pre_done;
            logic [7:0] top;
            logic       pwm;
            logic       at_end;
            logic       cnt_wr;
            logic [7:0] cnt_next;
            logic [1:0] sel;
            logic       level;

            assign tick[t] = src_tick(
                ctrl_reg[t][CTL_SRC_HI:CTL_SRC_LO], rise, fall);
            assign mask = pre_mask(
                scale_reg[t][SCL_PRE_HI:SCL_PRE_LO]);
            assign pre_done = tick[t] && ((pre_reg & mask) == mask);
            assign div_done[t] = pre_done &&
                (div_reg == scale_reg[t][SCL_DIV_HI:0]);
            assign top = !scale_reg[t][SCL_RES] ? MAX_8BIT :
                RESOLUTION_BUILD_OPTION ? MAX_7BIT : MAX_6BIT;
            assign pwm = ctrl_reg[t][CTL_MODE];
            assign at_end = pwm ? (cnt_reg[t] >= top)
                                : (cnt_reg[t] >= bound_reg[t]);
            assign cnt_wr = (t == 1) && wr &&
                hit(i_avs_address, IDX_COUNT[t]);
            assign cnt_next = cnt_wr ? wd :
                !div_done[t] ? cnt_reg[t] :
                at_end ? RST_BYTE : cnt_reg[t] + 8'h01;
            assign sel = ctrl_reg[t][CTL_OUT_HI:CTL_OUT_LO];
            assign level = wave_reg[t] ^ ctrl_reg[t][CTL_POL];

            // software-visible registers
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ctrl_reg[t]  <= RST_BYTE;
                    scale_reg[t] <= RST_BYTE;
                    bound_reg[t] <= RST_BYTE;
                end else if (wr) begin
                    if (hit(i_avs_address, IDX_CTRL[t])) begin
                        ctrl_reg[t] <= wd;
                    end
                    if (hit(i_avs_address, IDX_SCALE[t])) begin
                        scale_reg[t] <= wd;
                    end
                    if (hit(i_avs_address, IDX_BOUND[t])) begin
                        bound_reg[t] <= wd;
                    end
                end
            end

            // divider chain, counter and waveform
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pre_reg     <= 6'h00;
                    div_reg     <= 5'h00;
                    cnt_reg[t]  <= RST_BYTE;
                    wave_reg[t] <= 1'b0;
                end else begin
                    if (tick[t]) begin
                        pre_reg <= pre_reg + 6'h01;
                    end
                    if (div_done[t]) begin
                        div_reg <= 5'h00;
                    end else if (pre_done) begin
                        div_reg <= div_reg + 5'h01;
                    end
                    cnt_reg[t] <= cnt_next;
                    if (pwm) begin
                        wave_reg[t] <= cnt_reg[t] < bound_reg[t];
                    end else if (div_done[t] && at_end) begin
                        wave_reg[t] <= !wave_reg[t];
                    end
                end
            end

            // route level to the selected pin only
            for (genvar p = 0; p < 3; p++) begin : g_pin
                always_ff @(posedge i_mclk or negedge i_rst_n) begin
                    if (!i_rst_n) begin
                        pin_reg[t][p] <= 1'b0;
                        oe_reg[t][p]  <= 1'b0;
                    end else begin
                        oe_reg[t][p]  <= sel == 2'(p + 1);
                        pin_reg[t][p] <= (sel == 2'(p + 1)) && level;
                    end
                end
            end
        end
    endgenerate

    // pin mapping, all straight from flops
    assign o_port_b_pin2    = pin_reg[0][0];
    assign o_port_b_pin2_oe = oe_reg[0][0];
    assign o_port_a_pin3    = pin_reg[0][1];
    assign o_port_a_pin3_oe = oe_reg[0][1];
    assign o_port_b_pin4    = pin_reg[0][2];
    assign o_port_b_pin4_oe = oe_reg[0][2];
    assign o_port_b_pin5    = pin_reg[1][0];
    assign o_port_b_pin5_oe = oe_reg[1][0];
    assign o_port_b_pin6    = pin_reg[1][1];
    assign o_port_b_pin6_oe = oe_reg[1][1];
    assign o_port_b_pin7    = pin_reg[1][2];
    assign o_port_b_pin7_oe = oe_reg[1][2];

    // ************************************
    // assertions
    // ************************************
    property p_src_off;
        ctrl_reg[0][CTL_SRC_HI:CTL_SRC_LO] == SRC_OFF
        |=> cnt_reg[0] == $past(cnt_reg[0]);
    endproperty
    a_src_off: assert property (p_src_off) else $error("off counted");
    property p_pin_edge;
        ctrl_reg[1][CTL_SRC_HI:CTL_SRC_LO] == SRC_B0_F
        && !halt |-> tick[1] == fall[SY_B0];
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("edge tick");
    property p_fast_halt;
        halt && rise[SY_FAST] &&
        ctrl_reg[1][CTL_SRC_HI:CTL_SRC_LO] == SRC_FAST
        |-> tick[1];
    endproperty
    a_fast_halt: assert property (p_fast_halt) else $error("no tick");
    property p_route0;
        ctrl_reg[0][CTL_OUT_HI:CTL_OUT_LO] == 2'h2
        |=> o_port_a_pin3_oe && !o_port_b_pin2_oe && !o_port_b_pin4;
    endproperty
    a_route0: assert property (p_route0) else $error("misrouted");
    property p_route1;
        ctrl_reg[1][CTL_OUT_HI:CTL_OUT_LO] == 2'h0
        |=> !o_port_b_pin5_oe && !o_port_b_pin6_oe && !o_port_b_pin7_oe;
    endproperty
    a_route1: assert property (p_route1) else $error("pin driven");
    property p_polarity;
        ctrl_reg[0][CTL_OUT_HI:CTL_OUT_LO] == 2'h1
        |=> o_port_b_pin2 ==
            ($past(wave_reg[0]) ^ $past(ctrl_reg[0][CTL_POL]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity");
    property p_cnt_write;
        wr && hit(i_avs_address, IDX_COUNT[1]) |=> cnt_reg[1] == $past(wd);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("no write");
    property p_wrap;
        div_done[1] && ctrl_reg[1][CTL_MODE] && !g_tmr[1].cnt_wr &&
        scale_reg[1][SCL_RES] && cnt_reg[1] == MAX_6BIT &&
        !RESOLUTION_BUILD_OPTION |=> cnt_reg[1] == RST_BYTE;
    endproperty
    a_wrap: assert property (p_wrap) else $error("bad wrap");
    property p_pwm;
        ctrl_reg[0][CTL_MODE] ##1 ctrl_reg[0][CTL_MODE]
        |-> wave_reg[0] == ($past(cnt_reg[0]) < $past(bound_reg[0]));
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm level");
    property p_bus;
        req && wait_reg |=> !wait_reg ##1 wait_reg;
    endproperty
    a_bus: assert property (p_bus) else $error("wait state");

endmodule // dpt_top

// ### dpt_pkg.sv
package dpt_pkg;

    // ************************************
    // register indices (byte addr = 4*idx)
    // ************************************
    localparam logic [5:0] IDX_CTRL  [0:1] = '{6'h1c, 6'h32};
    localparam logic [5:0] IDX_COUNT [0:1] = '{6'h1d, 6'h33};
    localparam logic [5:0] IDX_SCALE [0:1] = '{6'h17, 6'h34};
    localparam logic [5:0] IDX_BOUND [0:1] = '{6'h09, 6'h35};
    localparam logic [7:0] RST_BYTE  = 8'h00;

    // ************************************
    // field positions
    // ************************************
    localparam int CTL_SRC_HI = 7;
    localparam int CTL_SRC_LO = 4;
    localparam int CTL_OUT_HI = 3;
    localparam int CTL_OUT_LO = 2;
    localparam int CTL_MODE   = 1;
    localparam int CTL_POL    = 0;
    localparam int SCL_RES    = 7;
    localparam int SCL_PRE_HI = 6;
    localparam int SCL_PRE_LO = 5;
    localparam int SCL_DIV_HI = 4;

    // ************************************
    // clock source codes
    // ************************************
    localparam logic [3:0] SRC_OFF   = 4'h0;
    localparam logic [3:0] SRC_SYS   = 4'h1;
    localparam logic [3:0] SRC_FAST  = 4'h2;
    localparam logic [3:0] SRC_SLOW  = 4'h4;
    localparam logic [3:0] SRC_CMP   = 4'h5;
    localparam logic [3:0] SRC_A0_R  = 4'h8;
    localparam logic [3:0] SRC_A0_F  = 4'h9;
    localparam logic [3:0] SRC_B0_R  = 4'ha;
    localparam logic [3:0] SRC_B0_F  = 4'hb;
    localparam logic [3:0] SRC_A4_R  = 4'hc;
    localparam logic [3:0] SRC_A4_F  = 4'hd;

    // ************************************
    // pre-divider masks and wrap limits
    // ************************************
    localparam logic [5:0] PRE_MASK_1  = 6'h00;
    localparam logic [5:0] PRE_MASK_4  = 6'h03;
    localparam logic [5:0] PRE_MASK_16 = 6'h0f;
    localparam logic [5:0] PRE_MASK_64 = 6'h3f;
    localparam logic [7:0] MAX_8BIT    = 8'hff;
    localparam logic [7:0] MAX_7BIT    = 8'h7f;
    localparam logic [7:0] MAX_6BIT    = 8'h3f;

    // synchronised input bit positions
    localparam int SY_FAST = 0;
    localparam int SY_SLOW = 1;
    localparam int SY_CMP  = 2;
    localparam int SY_A0   = 3;
    localparam int SY_B0   = 4;
    localparam int SY_A4   = 5;
    localparam int SY_HALT = 6;
    localparam int SY_W    = 7;

endpackage

// ### dpt_far.sv
// ************************************
// pin-side model: clock sources and pin wires
// ************************************
module dpt_far (
    input  wire logic       i_mclk,
    input  wire logic [5:0] i_pin_val,
    input  wire logic [5:0] i_pin_oe,
    output logic      [5:0] o_src
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [5:0] pin_wire;

    // undriven pins fall to the pull-down level
    assign pin_wire = i_pin_val & i_pin_oe;

    initial o_src = 6'h00;

    // n rising and n-1 falling edges, 3 cycles a level, ends high
    task automatic pulse(input int idx, input int n);
        for (int k = 0; k < 2 * n - 1; k++) begin
            @(posedge i_mclk);
            o_src[idx] <= ~o_src[idx];
            repeat (2) @(posedge i_mclk);
        end
    endtask

    // return a source line to its idle low level
    task automatic drop(input int idx);
        @(posedge i_mclk);
        o_src[idx] <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask

    // count the cycles a pin wire spends high
    task automatic measure(input int pin, input int cycles, output int hi);
        hi = 0;
        repeat (cycles) begin
            @(posedge i_mclk);
            hi += int'(pin_wire[pin]);
        end
    endtask
endmodule // dpt_far

// ### dual_pwm_period_timer_tb.sv
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
    bad_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
    end end

module dual_pwm_period_timer_tb;
    import dpt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        int         t;
        int         sel;
        logic       mode;
        logic       inv;
        logic [7:0] scl;
        logic [7:0] bnd;
    } dpt_case_t;

    localparam int NP = 5;
    logic        i_mclk, i_rst_n, avs_read, avs_write, halt;
    logic [7:0]  avs_address, rd;
    logic [31:0] avs_writedata, avs_readdata;
    logic        waitreq;
    logic [5:0]  src, pin_val, pin_oe;
    int          bad_count, n_compared, win, hi, seen, pix;
    integer      seed;
    logic [3:0]  codes [0:9];
    int          cidx  [0:9];
    logic [5:0]  ridx  [0:7];
    dpt_case_t   cases [0:5];

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    dpt_top #(.RESOLUTION_BUILD_OPTION(1'b0)) i_dpt_top (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_byteenable(4'h1),
        .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
        .o_avs_waitrequest(waitreq),
        .i_fast_rc_oscillator(src[SY_FAST]),
        .i_slow_rc_oscillator(src[SY_SLOW]),
        .i_comparator_out(src[SY_CMP]), .i_port_a_pin0(src[SY_A0]),
        .i_port_b_pin0(src[SY_B0]), .i_port_a_pin4(src[SY_A4]),
        .i_incircuit_emulator_halt(halt),
        .o_port_b_pin2(pin_val[0]), .o_port_b_pin2_oe(pin_oe[0]),
        .o_port_a_pin3(pin_val[1]), .o_port_a_pin3_oe(pin_oe[1]),
        .o_port_b_pin4(pin_val[2]), .o_port_b_pin4_oe(pin_oe[2]),
        .o_port_b_pin5(pin_val[3]), .o_port_b_pin5_oe(pin_oe[3]),
        .o_port_b_pin6(pin_val[4]), .o_port_b_pin6_oe(pin_oe[4]),
        .o_port_b_pin7(pin_val[5]), .o_port_b_pin7_oe(pin_oe[5])
    );

    dpt_far i_dpt_far (
        .i_mclk(i_mclk), .i_pin_val(pin_val), .i_pin_oe(pin_oe),
        .o_src(src)
    );

    // ************************************
    // bus tasks and reference model
    // ************************************
    // hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd, output logic [7:0] rdv);
        int guard;
        guard = 0;
        @(posedge i_mclk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, wd};
        do begin
            @(posedge i_mclk);
            guard++;
        end while (waitreq !== 1'b0);
        rdv = avs_readdata[7:0];
        `CHK("wait_edges", 2, guard)
        `CHK("readdata_hi", 24'h000000, avs_readdata[31:8])
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // read-back of a write is dropped so the caller's rd survives
    task automatic wreg(input logic [5:0] idx, input logic [7:0] wd);
        logic [7:0] unused_rd;
        bus(1'b1, idx, wd, unused_rd);
    endtask

    task automatic chk(input logic [5:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00, rd);
        `CHK("register", ex, rd)
    endtask

    function automatic int exp_cnt(input logic [3:0] c, input logic h);
        if (c == SRC_OFF || (h && c != SRC_FAST)) return 0;
        return (c[3] && c[0]) ? NP - 1 : NP;
    endfunction

    // window of one waveform period and its expected high cycles
    function automatic void exp_duty(input dpt_case_t c, output int w,
                                     output int h);
        int dv, top;
        dv = (int'(c.scl[4:0]) + 1) * (1 << (2 * int'(c.scl[6:5])));
        top = c.scl[7] ? 64 : 256;
        if (c.mode) begin
            w = top * dv;
            h = ((int'(c.bnd) < top) ? int'(c.bnd) : top) * dv;
        end else begin
            w = 2 * (int'(c.bnd) + 1) * dv;
            h = (int'(c.bnd) + 1) * dv;
        end
        if (c.inv) h = w - h;
    endfunction

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_mclk);
        bad_count++;
        $display("CHECK FAILED watchdog exp done got hang");
        finish_test();
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        {avs_read, avs_write, halt, avs_address, avs_writedata} = '0;
        {bad_count, n_compared} = '0;
        seed = 32'he78ecf0b;
        i_rst_n = 1'b0;
        codes = '{SRC_OFF, SRC_FAST, SRC_SLOW, SRC_CMP, SRC_A0_R,
                  SRC_A0_F, SRC_B0_R, SRC_B0_F, SRC_A4_R, SRC_A4_F};
        cidx = '{3, 0, 1, 2, 3, 3, 4, 4, 5, 5};
        // the first counter is never read
        ridx = '{IDX_CTRL[0], IDX_CTRL[1], IDX_COUNT[1], IDX_SCALE[0],
                 IDX_SCALE[1], IDX_BOUND[0], IDX_BOUND[1], 6'h3f};
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        foreach (ridx[i]) chk(ridx[i], RST_BYTE);
        for (int t = 0; t < 2; t++) begin
            rd = 8'($random(seed));
            wreg(IDX_CTRL[t], rd);
            chk(IDX_CTRL[t], rd);
            wreg(IDX_CTRL[t], 8'h00);
            wreg(IDX_BOUND[t], 8'ha5);
            chk(IDX_BOUND[t], 8'h00);
        end
        rd = 8'($random(seed));
        wreg(IDX_COUNT[1], rd);
        chk(IDX_COUNT[1], rd);
        wreg(6'h3f, 8'h5a);
        chk(6'h3f, 8'h00);
        // every clock source but the system clock, then again under emulator halt
        for (int h = 0; h < 2; h++) begin
            halt <= h[0];
            repeat (4) @(posedge i_mclk);
            for (int i = 0; i < 10; i++) begin
                wreg(IDX_CTRL[1], {codes[i], 4'h2});
                wreg(IDX_COUNT[1], 8'h00);
                i_dpt_far.pulse(cidx[i], NP);
                repeat (8) @(posedge i_mclk);
                chk(IDX_COUNT[1], 8'(exp_cnt(codes[i], h[0])));
                wreg(IDX_CTRL[1], 8'h00);
                i_dpt_far.drop(cidx[i]);
            end
        end
        halt <= 1'b0;
        // waveform cases on every pin, system clock source
        cases = '{'{0, 1, 1'b1, 1'b0, 8'h00, 8'($random(seed))},
                  '{0, 2, 1'b1, 1'b1, 8'h21, 8'h10},
                  '{0, 3, 1'b0, 1'b0, 8'h60, 8'h09},
                  '{1, 1, 1'b1, 1'b0, 8'h80, 8'h20},
                  '{1, 2, 1'b1, 1'b0, 8'h80, 8'h50},
                  '{1, 3, 1'b0, 1'b1, 8'h41, 8'h03}};
        foreach (cases[i]) begin
            wreg(IDX_SCALE[cases[i].t], cases[i].scl);
            wreg(IDX_BOUND[cases[i].t], cases[i].bnd);
            wreg(IDX_CTRL[cases[i].t], {SRC_SYS, 2'(cases[i].sel),
                 cases[i].mode, cases[i].inv});
            exp_duty(cases[i], win, hi);
            repeat (2 * win + 64) @(posedge i_mclk);
            pix = cases[i].t * 3 + cases[i].sel - 1;
            `CHK("pin_oe", 6'(1 << pix), pin_oe)
            i_dpt_far.measure(pix, win, seen);
            `CHK("high_cycles", hi, seen)
            wreg(IDX_CTRL[cases[i].t], 8'h00);
        end
        finish_test();
    end
endmodule // dual_pwm_period_timer_tb
